// File: cmpmx_ctrl.sv
// Function
// - Mode register bits 7-6 and 3-2 read zero, writes there ignored
// - Rise interrupt enable lets a set rising flag request the interrupt
// - Fall interrupt enable lets a set falling flag request the interrupt
// - Mode bits 1-0 pick response time, driven to analog core
// - Mux high nibble picks negative input pin, top bit means none
// - Mux low nibble picks positive input pin, top bit means none
// - Raw comparator output reaches P1.2 only with crossbar bit 5
// - Synchronised output reaches P1.3 only with crossbar bit 4
// - Rising and falling edges set sticky flags until software clears
// - Disabled comparator holds any routed output pin low
`timescale 1ns/1ps
module cmpmx_ctrl
    import cmpmx_pkg::*;
(
    input  wire logic              i_clk_sys,
    input  wire logic              i_nrst,
    input  wire logic [7:0]        i_sfr_addr,
    input  wire logic              i_sfr_wr,
    input  wire logic              i_sfr_rd,
    input  wire logic [7:0]        i_sfr_wdata,
    output logic [7:0]             o_sfr_rdata,
    output logic                   o_sfr_hit,
    input  wire logic              i_comparator_on,
    input  wire logic              i_raw_compare_out,
    input  wire logic [7:0]        i_crossbar_enable_reg,
    input  wire logic              i_rise_flag_clr,
    input  wire logic              i_fall_flag_clr,
    output logic                   o_rise_edge_flag,
    output logic                   o_fall_edge_flag,
    output logic                   o_compare_result_bit,
    output logic                   o_cmp_irq,
    output cmpmx_pkg::cmpmx_md_e   o_response_mode_code,
    output logic [7:0]             o_minus_pin_sel,
    output logic [7:0]             o_plus_pin_sel,
    output cmpmx_pkg::cmpmx_pin_s  o_p1_2,
    output cmpmx_pkg::cmpmx_pin_s  o_p1_3
);
    import cmpmx_pkg::*;

    cmpmx_mode_s mode_reg;
    cmpmx_mux_s  mux_reg;
    logic        synced_compare_out;
    logic        prev_reg;
    logic        rise_evt;
    logic        fall_evt;

    // Nibble to one-hot pin select; top bit set leaves every pin open
    function automatic logic [7:0] sel_decode(input logic [3:0] code);
        logic [7:0] onehot;
        onehot = 8'h00;
        if (!code[3]) begin
            onehot[code[2:0]] = 1'b1;
        end
        return onehot;
    endfunction : sel_decode

    // Mode register; only the four live bits are stored
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            mode_reg <= cmpmx_mode_s'({CMPMX_MODE_RESET[CMPMX_RIE_BIT],
                                       CMPMX_MODE_RESET[CMPMX_FIE_BIT],
                                       CMPMX_MODE_RESET[CMPMX_MD_LSB+:2]});
        end else if (i_sfr_wr && i_sfr_addr == CMPMX_MODE_ADDR) begin
            mode_reg.rise_irq_enable    <= i_sfr_wdata[CMPMX_RIE_BIT];
            mode_reg.fall_irq_enable    <= i_sfr_wdata[CMPMX_FIE_BIT];
            mode_reg.response_mode_code <= cmpmx_md_e'(i_sfr_wdata[CMPMX_MD_LSB+:2]);
        end
    end

    // Mux register, fully writable
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            mux_reg <= cmpmx_mux_s'(CMPMX_MUX_RESET);
        end else if (i_sfr_wr && i_sfr_addr == CMPMX_MUX_ADDR) begin
            mux_reg <= cmpmx_mux_s'(i_sfr_wdata);
        end
    end

    // Registered read port; other addresses answer zero with no hit
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit   <= 1'b0;
        end else if (i_sfr_rd && i_sfr_addr == CMPMX_MODE_ADDR) begin
            o_sfr_rdata <= {2'h0, mode_reg.rise_irq_enable, mode_reg.fall_irq_enable,
                            2'h0, mode_reg.response_mode_code};
            o_sfr_hit   <= 1'b1;
        end else if (i_sfr_rd && i_sfr_addr == CMPMX_MUX_ADDR) begin
            o_sfr_rdata <= mux_reg;
            o_sfr_hit   <= 1'b1;
        end else begin
            o_sfr_rdata <= 8'h00;
            o_sfr_hit   <= 1'b0;
        end
    end

    // Raw result is asynchronous, so it is synchronised first
    cmpmx_sync #(
        .DEPTH    (CMPMX_SYNC_DEPTH)
    ) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_nrst   (i_nrst),
        .i_async  (i_raw_compare_out),
        .o_sync   (synced_compare_out)
    );

    // Edge detector on the synchronised value only
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            prev_reg <= 1'b0;
        end else begin
            prev_reg <= synced_compare_out;
        end
    end

    assign rise_evt             = synced_compare_out && !prev_reg;
    assign fall_evt             = !synced_compare_out && prev_reg;
    assign o_compare_result_bit = synced_compare_out;

    // Sticky flags; an edge in the clearing cycle wins so none is lost
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            o_rise_edge_flag <= 1'b0;
            o_fall_edge_flag <= 1'b0;
        end else begin
            o_rise_edge_flag <= rise_evt || (o_rise_edge_flag && !i_rise_flag_clr);
            o_fall_edge_flag <= fall_evt || (o_fall_edge_flag && !i_fall_flag_clr);
        end
    end

    // Single interrupt request from both gated flags
    assign o_cmp_irq = (o_rise_edge_flag && mode_reg.rise_irq_enable)
                    || (o_fall_edge_flag && mode_reg.fall_irq_enable);

    // Analog-side selections
    assign o_response_mode_code = mode_reg.response_mode_code;
    assign o_minus_pin_sel      = sel_decode(mux_reg.negative_input_select);
    assign o_plus_pin_sel       = sel_decode(mux_reg.positive_input_select);

    // Raw path stays combinational so it works without the clock
    assign o_p1_2.oe  = i_crossbar_enable_reg[CMPMX_XB_RAW_BIT];
    assign o_p1_2.out = o_p1_2.oe && i_comparator_on && i_raw_compare_out;
    assign o_p1_3.oe  = i_crossbar_enable_reg[CMPMX_XB_SYN_BIT];
    assign o_p1_3.out = o_p1_3.oe && i_comparator_on && synced_compare_out;

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_nrst);

    property p_mode_rsvd;
        i_sfr_rd && i_sfr_addr == CMPMX_MODE_ADDR |=> (o_sfr_rdata & ~CMPMX_MODE_MASK) == 8'h00;
    endproperty
    a_mode_rsvd: assert property (p_mode_rsvd) else $error("reserved mode bits nonzero");

    // A rising edge with the enable held must raise the request one cycle on
    property p_rise_irq;
        rise_evt && mode_reg.rise_irq_enable && !(i_sfr_wr && i_sfr_addr == CMPMX_MODE_ADDR)
            |=> o_cmp_irq;
    endproperty
    a_rise_irq: assert property (p_rise_irq) else $error("rise flag did not interrupt");

    property p_fall_irq;
        fall_evt && mode_reg.fall_irq_enable && !(i_sfr_wr && i_sfr_addr == CMPMX_MODE_ADDR)
            |=> o_cmp_irq;
    endproperty
    a_fall_irq: assert property (p_fall_irq) else $error("fall flag did not interrupt");

    property p_irq_cause;
        o_cmp_irq |-> (o_rise_edge_flag && mode_reg.rise_irq_enable)
                   || (o_fall_edge_flag && mode_reg.fall_irq_enable);
    endproperty
    a_irq_cause: assert property (p_irq_cause) else $error("interrupt without cause");

    property p_mode_out;
        i_sfr_wr && i_sfr_addr == CMPMX_MODE_ADDR
            |=> o_response_mode_code == $past(i_sfr_wdata[1:0]);
    endproperty
    a_mode_out: assert property (p_mode_out) else $error("mode code not updated");

    property p_neg_sel;
        mux_reg.negative_input_select[3] |-> o_minus_pin_sel == 8'h00;
    endproperty
    a_neg_sel: assert property (p_neg_sel) else $error("negative pin selected when none");

    property p_pos_sel;
        !mux_reg.positive_input_select[3]
            |-> o_plus_pin_sel == (8'h01 << mux_reg.positive_input_select[2:0]);
    endproperty
    a_pos_sel: assert property (p_pos_sel) else $error("positive pin select wrong");

    property p_raw_pin;
        !i_crossbar_enable_reg[CMPMX_XB_RAW_BIT] |-> !o_p1_2.out && !o_p1_2.oe;
    endproperty
    a_raw_pin: assert property (p_raw_pin) else $error("raw output routed while off");

    property p_sync_pin;
        !i_crossbar_enable_reg[CMPMX_XB_SYN_BIT] |-> !o_p1_3.out && !o_p1_3.oe;
    endproperty
    a_sync_pin: assert property (p_sync_pin) else $error("synced output routed while off");

    property p_rise_set;
        rise_evt |=> o_rise_edge_flag;
    endproperty
    a_rise_set: assert property (p_rise_set) else $error("rising edge not flagged");

    property p_fall_hold;
        o_fall_edge_flag && !i_fall_flag_clr |=> o_fall_edge_flag;
    endproperty
    a_fall_hold: assert property (p_fall_hold) else $error("fall flag dropped");

    property p_off_low;
        !i_comparator_on |-> !o_p1_2.out && !o_p1_3.out;
    endproperty
    a_off_low: assert property (p_off_low) else $error("pin high while disabled");

    property p_sync_lat;
        $rose(i_raw_compare_out) ##1 i_raw_compare_out |=> o_compare_result_bit;
    endproperty
    a_sync_lat: assert property (p_sync_lat) else $error("synchroniser latency wrong");

    c_rise_irq: cover property (rise_evt && mode_reg.rise_irq_enable ##1 o_cmp_irq);
    c_fall_irq: cover property (fall_evt && mode_reg.fall_irq_enable ##1 o_cmp_irq);
    c_clr_set:  cover property (rise_evt && i_rise_flag_clr && o_rise_edge_flag);
    c_pin_out:  cover property (o_p1_3.out && o_p1_2.out);

endmodule : cmpmx_ctrl

// File: cmpmx_pkg.sv
package cmpmx_pkg;

    // Special-function register addresses
    localparam logic [7:0] CMPMX_MODE_ADDR  = 8'h9d;
    localparam logic [7:0] CMPMX_MUX_ADDR   = 8'h9f;

    // Reset values
    localparam logic [7:0] CMPMX_MODE_RESET = 8'h02;
    localparam logic [7:0] CMPMX_MUX_RESET  = 8'hff;

    // Mode register field positions and writable mask
    localparam int         CMPMX_RIE_BIT    = 5;
    localparam int         CMPMX_FIE_BIT    = 4;
    localparam int         CMPMX_MD_LSB     = 0;
    localparam logic [7:0] CMPMX_MODE_MASK  = 8'h33;

    // Mux register field positions; top bit of each field means no pin
    localparam int         CMPMX_NSEL_LSB   = 4;
    localparam int         CMPMX_PSEL_LSB   = 0;
    localparam int         CMPMX_SEL_W      = 4;
    localparam int         CMPMX_PINS       = 8;

    // Crossbar enable bits for the two comparator outputs
    localparam int         CMPMX_XB_RAW_BIT = 5;
    localparam int         CMPMX_XB_SYN_BIT = 4;

    // Synchroniser depth
    localparam int         CMPMX_SYNC_DEPTH = 2;

    // Response-time codes
    typedef enum logic [1:0] {
        CMPMX_MD_FAST  = 2'h0,
        CMPMX_MD_MID1  = 2'h1,
        CMPMX_MD_MID2  = 2'h2,
        CMPMX_MD_LOWPW = 2'h3
    } cmpmx_md_e;

    // Stored fields of the mode register
    typedef struct packed {
        logic      rise_irq_enable;
        logic      fall_irq_enable;
        cmpmx_md_e response_mode_code;
    } cmpmx_mode_s;

    // Stored fields of the mux register
    typedef struct packed {
        logic [3:0] negative_input_select;
        logic [3:0] positive_input_select;
    } cmpmx_mux_s;

    // One pin output with its enable
    typedef struct packed {
        logic out;
        logic oe;
    } cmpmx_pin_s;

endpackage : cmpmx_pkg

// File: cmpmx_sync.sv
`timescale 1ns/1ps
module cmpmx_sync #(
    parameter int DEPTH = 2
) (
    input  wire logic i_clk_sys,
    input  wire logic i_nrst,
    input  wire logic i_async,
    output logic      o_sync
);
    logic [DEPTH-1:0] stage_reg;

    // Plain shift chain; only the last stage is read outside
    always_ff @(posedge i_clk_sys) begin
        if (!i_nrst) begin
            stage_reg <= '0;
        end else begin
            stage_reg <= {stage_reg[DEPTH-2:0], i_async};
        end
    end

    assign o_sync = stage_reg[DEPTH-1];
endmodule : cmpmx_sync

// File: cmpmx_analog_model.sv
`timescale 1ns/1ps
module cmpmx_analog_model (
    input  wire logic       i_clk_sys,
    input  wire logic [7:0] i_plus_sel,
    input  wire logic [7:0] i_minus_sel,
    input  wire logic [7:0] i_plus_lvl,
    input  wire logic [7:0] i_minus_lvl,
    input  wire logic       i_slow,
    output logic            o_raw
);
    logic [2:0] settle_reg;
    logic       cmp_level;
    // Unselected inputs count as low, so a none code on the plus side never compares high
    assign cmp_level = |(i_plus_sel & i_plus_lvl) > |(i_minus_sel & i_minus_lvl);
    // Slow response modes settle later; output moves just after the edge
    always @(posedge i_clk_sys) begin
        settle_reg <= #1 {settle_reg[1:0], cmp_level};
    end
    assign o_raw = i_slow ? settle_reg[2] : settle_reg[0];
endmodule : cmpmx_analog_model

// File: test_comparator_mode_mux_control.sv
`timescale 1ns/1ps
module test_comparator_mode_mux_control;
    import cmpmx_pkg::*;
    typedef struct {logic [7:0] a; logic [7:0] d; logic [7:0] r;} cmpmx_row_s;
    logic       clk, nrst, wr, rd, on, rclr, fclr, slow, raw, hit, rf, ff, res, irq, h;
    logic [7:0] addr, wd, rdata, msel, psel, xbar, plvl, v;
    cmpmx_md_e  md;
    cmpmx_pin_s p12, p13;
    int         error_cnt = 0;
    int         samples_checked = 0;
    // Writes then read-back, unmapped address last
    cmpmx_row_s rows[5] = '{'{8'h9d, 8'hff, 8'h33}, '{8'h9d, 8'hcc, 8'h00},
        '{8'h9d, 8'h21, 8'h21}, '{8'h9f, 8'ha5, 8'ha5}, '{8'h9e, 8'h5a, 8'h00}};

    cmpmx_ctrl dut (.i_clk_sys(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wr(wr),
        .i_sfr_rd(rd), .i_sfr_wdata(wd), .o_sfr_rdata(rdata), .o_sfr_hit(hit),
        .i_comparator_on(on), .i_raw_compare_out(raw), .i_crossbar_enable_reg(xbar),
        .i_rise_flag_clr(rclr), .i_fall_flag_clr(fclr), .o_rise_edge_flag(rf),
        .o_fall_edge_flag(ff), .o_compare_result_bit(res), .o_cmp_irq(irq),
        .o_response_mode_code(md), .o_minus_pin_sel(msel), .o_plus_pin_sel(psel),
        .o_p1_2(p12), .o_p1_3(p13));
    cmpmx_analog_model u_model (.i_clk_sys(clk), .i_plus_sel(psel), .i_minus_sel(msel),
        .i_plus_lvl(plvl), .i_minus_lvl(8'h00), .i_slow(slow), .o_raw(raw));

    // 200 MHz system clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wd   <= d;
        wr   <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : wr_reg

    // Read data and hit stand for one cycle only, so sample right after
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        v = rdata;
        h = hit;
    endtask : rd_reg

    // Drive the selected plus pin, then wait until the flag edge has landed
    task automatic drive_wait(input logic lvl);
        int n;
        n = 0;
        @(posedge clk);
        plvl <= {7'h00, lvl};
        while (res !== lvl && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) chk(8'h01, 8'h00);
        @(posedge clk);
        #1;
    endtask : drive_wait

    task automatic clr(input logic r, input logic f);
        @(posedge clk);
        rclr <= r;
        fclr <= f;
        @(posedge clk);
        rclr <= 1'b0;
        fclr <= 1'b0;
        #1;
    endtask : clr

    task automatic stop_test();
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : stop_test

    // Whole run is under a thousand cycles; five times that means a hang
    initial begin
        #25000;
        error_cnt++;
        stop_test();
    end

    initial begin
        {nrst, wr, rd, on, rclr, fclr, slow} = '0;
        {addr, wd, xbar, plvl} = '0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        rd_reg(8'h9d);
        chk(v, 8'h02);
        rd_reg(8'h9f);
        chk(v, 8'hff);
        chk(psel | msel, 8'h00);
        foreach (rows[i]) begin
            wr_reg(rows[i].a, rows[i].d);
            rd_reg(rows[i].a);
            chk(v, rows[i].r);
            chk({7'h00, h}, {7'h00, rows[i].a != 8'h9e});
        end
        for (int m = 0; m < 4; m++) begin
            wr_reg(8'h9d, 8'(m));
            chk({6'h00, md}, 8'(m));
        end
        for (int c = 0; c < 16; c++) begin
            wr_reg(8'h9f, {4'(c), 4'(c)});
            chk(msel, c < 8 ? 8'h01 << c : 8'h00);
            chk(psel, c < 8 ? 8'h01 << c : 8'h00);
        end
        $display("test registers done");
        // Both inputs on P0.0, both comparator outputs routed through the crossbar
        wr_reg(8'h9f, 8'h00);
        @(posedge clk);
        xbar <= 8'h30;
        on   <= 1'b1;
        wr_reg(8'h9d, 8'h20);
        clr(1'b1, 1'b1);
        // Clear pulse lands in the very cycle of a rising edge; the set wins
        @(posedge clk);
        plvl <= 8'h01;
        repeat (3) @(posedge clk);
        rclr <= 1'b1;
        @(posedge clk);
        rclr <= 1'b0;
        #1;
        chk({7'h00, rf}, 8'h01);
        drive_wait(1'b0);
        clr(1'b1, 1'b1);
        for (int s = 0; s < 2; s++) begin
            @(posedge clk);
            slow <= s[0];
            drive_wait(1'b1);
            chk({5'h00, rf, ff, irq}, 8'h05);
            chk({4'h0, p12, p13}, 8'h0f);
            drive_wait(1'b0);
            chk({5'h00, rf, ff, irq}, 8'h07);
            clr(1'b1, 1'b0);
            chk({5'h00, rf, ff, irq}, 8'h02);
            wr_reg(8'h9d, 8'h10);
            chk({5'h00, rf, ff, irq}, 8'h03);
            clr(1'b0, 1'b1);
            wr_reg(8'h9d, 8'h20);
        end
        $display("test edges done");
        @(posedge clk);
        on <= 1'b0;
        drive_wait(1'b1);
        chk({4'h0, p12, p13}, 8'h05);
        @(posedge clk);
        xbar <= 8'h00;
        @(posedge clk);
        #1;
        chk({4'h0, p12, p13}, 8'h00);
        // Reset in mid-run with a flag set
        @(posedge clk);
        nrst <= 1'b0;
        @(posedge clk);
        nrst <= 1'b1;
        rd_reg(8'h9d);
        chk(v, 8'h02);
        chk({6'h00, rf, ff}, 8'h00);
        $display("test pins and reset done");
        stop_test();
    end
endmodule : test_comparator_mode_mux_control
